// file: etc_pkg.sv
// package for the event timer / pulse width counter
// assumes a single 100 MHz system clock and a plain register port
package etc_pkg;
    localparam logic [7:0] ADDR_COUNT = 8'h0D;
    localparam logic [7:0] ADDR_CTRL = 8'h0E;
    localparam logic [7:0] ADDR_IRQ = 8'h0F;
    localparam logic [7:0] ADDR_PORT = 8'h10;
    localparam int PSC_LSB = 0;
    localparam int PSC_MSB = 2;
    localparam int EDGE_BIT = 3;
    localparam int RUN_BIT = 4;
    localparam int MODE_LSB = 6;
    localparam int MODE_MSB = 7;
    localparam int IRQ_FLAG_BIT = 5;
    localparam int IRQ_EN_BIT = 2;
    localparam int PFD_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [7:0] CTRL_WMASK = 8'hDF;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [6:0] PSC_ONE = 7'h01;
    typedef enum logic [1:0] {
        ETC_MODE_NONE = 2'b00,
        ETC_MODE_EVENT = 2'b01,
        ETC_MODE_TIMER = 2'b10,
        ETC_MODE_PULSE = 2'b11
    } etc_mode_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } etc_bus_type;
endpackage

// file: etc_timer.sv
// 8-bit event timer with preload, prescaler, pulse width mode and divider output
// assumes synchronous reset, clock enable from the same domain, pin input async
//
// Contract
// R01: one 8-bit up-counter clocked by event pin or prescaled system clock
// R02: count write updates preload; loads counter too while counting is off
// R03: count read returns counter and blocks the count clock that cycle
// R04: mode field 7:6 selects event, timer, pulse width; 00 unused
// R05: event and timer modes count to FFH then reload from preload
// R06: each overflow sets the overflow flag at irq bit 5
// R07: flag reaches the irq output only when enable bit 2 is set
// R08: event mode edge bit 1 counts falling edges, 0 rising edges
// R09: pulse mode measures high level for polarity 1, low level for 0
// R10: pulse mode clears run bit at end, holds result until rerun
// R11: overflow in pulse mode reloads and raises the flag as well
// R12: run bit 4 gates counting; only software clears it outside pulse mode
// R13: control bits 2:0 choose divide by 1 up to 128
// R14: control bit 5 is unimplemented and reads as zero
// R15: overflow is a wake-up source ending halt
// R16: divider output on port bit 3 only while its latch is one
// R17: divider output toggles on each overflow
// R18: prescaler chain also times the pwm generator
// R19: software loads a start count before first run
// R20: software toggles run on then off once before first use
// R21: event pin passes a two-stage synchroniser before edge detection
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module etc_timer (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // pins and system hooks
    input wire logic count_and_event_pin,
    input wire logic freq_out_option,
    output logic port_a_bit3,
    output logic irq,
    output logic wake_up,
    output logic [6:0] pwm_time_base
);
    etc_pkg::etc_bus_type bus;
    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    logic [7:0] count_q;
    logic [7:0] preload_q;
    logic [7:0] ctrl_q;
    logic flag_q;
    logic irq_en_q;
    logic latch_q;
    logic pfd_q;
    logic [6:0] psc_q;
    logic [6:0] psc_d;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic [7:0] rdata_q;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    wire logic wr_count = bus.wr && addr_is(bus.addr, etc_pkg::ADDR_COUNT);
    wire logic wr_ctrl = bus.wr && addr_is(bus.addr, etc_pkg::ADDR_CTRL);
    wire logic wr_irq = bus.wr && addr_is(bus.addr, etc_pkg::ADDR_IRQ);
    wire logic wr_port = bus.wr && addr_is(bus.addr, etc_pkg::ADDR_PORT);
    wire logic rd_count = bus.rd && addr_is(bus.addr, etc_pkg::ADDR_COUNT);

    etc_pkg::etc_mode_type mode;
    assign mode = etc_pkg::etc_mode_type'(ctrl_q[etc_pkg::MODE_MSB:etc_pkg::MODE_LSB]); // [R04]
    wire logic run = ctrl_q[etc_pkg::RUN_BIT]; // [R12]
    wire logic polarity = ctrl_q[etc_pkg::EDGE_BIT];
    wire logic [2:0] psc_sel = ctrl_q[etc_pkg::PSC_MSB:etc_pkg::PSC_LSB];

    // two-stage synchroniser, then edge stage
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else if (clk_en) begin
            pin_s1_q <= count_and_event_pin; // [R21]
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    wire logic pin_rise = pin_s2_q && !pin_s3_q;
    wire logic pin_fall = !pin_s2_q && pin_s3_q;

    // free running prescaler chain, shared with the pwm
    assign psc_d = psc_q + etc_pkg::PSC_ONE;
    always_ff @(posedge clk) begin
        if (reset) begin
            psc_q <= '0;
        end else if (clk_en) begin
            psc_q <= psc_d;
        end
    end
    assign pwm_time_base = psc_q; // [R18]

    // mask of the low chain bits that must all be one for a tick
    function automatic logic [6:0] psc_mask(input logic [2:0] sel);
        psc_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction
    // tick when the low sel bits of the chain are all ones: divide by 2^sel
    logic psc_tick;
    always_comb begin
        psc_tick = ((psc_q & psc_mask(psc_sel)) == psc_mask(psc_sel)); // [R13]
    end

    // pulse width measurement state
    logic measuring_q;
    wire logic start_edge = polarity ? pin_rise : pin_fall; // [R09]
    wire logic stop_edge = polarity ? pin_fall : pin_rise; // [R09]
    wire logic pulse_mode = (mode == etc_pkg::ETC_MODE_PULSE);
    wire logic pulse_done = pulse_mode && run && measuring_q && stop_edge;

    always_ff @(posedge clk) begin
        if (reset) begin
            measuring_q <= 1'b0;
        end else if (clk_en) begin
            if (!pulse_mode || !run || pulse_done) begin
                measuring_q <= 1'b0;
            end else if (start_edge) begin
                measuring_q <= 1'b1;
            end
        end
    end

    // count clock selection, blocked during a read
    logic count_tick;
    always_comb begin
        case (mode)
            etc_pkg::ETC_MODE_EVENT: count_tick = polarity ? pin_fall : pin_rise; // [R08]
            etc_pkg::ETC_MODE_TIMER: count_tick = psc_tick;
            etc_pkg::ETC_MODE_PULSE: count_tick = psc_tick && measuring_q && !stop_edge;
            default: count_tick = 1'b0;
        endcase
    end
    wire logic count_step = run && count_tick && !rd_count; // [R03] [R01]
    wire logic overflow = count_step && (count_q == etc_pkg::COUNT_MAX);

    // preload register
    always_ff @(posedge clk) begin
        if (reset) begin
            preload_q <= etc_pkg::ZERO8;
        end else if (clk_en && wr_count) begin
            preload_q <= bus.wdata; // [R02]
        end
    end

    // counter
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= etc_pkg::ZERO8;
        end else if (clk_en) begin
            if (wr_count && !run) begin
                count_q <= bus.wdata; // [R02]
            end else if (overflow) begin
                count_q <= preload_q; // [R05] [R11]
            end else if (count_step) begin
                count_q <= count_q + 8'h01; // [R01]
            end
        end
    end

    // control register; hardware clears run at end of a pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= etc_pkg::CTRL_RESET;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_q <= bus.wdata & etc_pkg::CTRL_WMASK; // [R14] [R12]
            end else if (pulse_done) begin
                ctrl_q[etc_pkg::RUN_BIT] <= 1'b0; // [R10]
            end
        end
    end

    // interrupt flag and enable; set wins over a software clear
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_irq) begin
                irq_en_q <= bus.wdata[etc_pkg::IRQ_EN_BIT];
            end
            if (overflow) begin
                flag_q <= 1'b1; // [R06]
            end else if (wr_irq) begin
                flag_q <= bus.wdata[etc_pkg::IRQ_FLAG_BIT];
            end
        end
    end
    assign irq = flag_q && irq_en_q; // [R07]
    assign wake_up = overflow; // [R15]

    // divider output and port latch
    always_ff @(posedge clk) begin
        if (reset) begin
            pfd_q <= 1'b0;
            latch_q <= 1'b1;
        end else if (clk_en) begin
            if (overflow) begin
                pfd_q <= !pfd_q; // [R17]
            end
            if (wr_port) begin
                latch_q <= bus.wdata[etc_pkg::PFD_BIT];
            end
        end
    end
    assign port_a_bit3 = freq_out_option ? (latch_q && pfd_q) : latch_q; // [R16]

    // read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= etc_pkg::ZERO8;
        end else if (clk_en) begin
            rdata_q <= etc_pkg::ZERO8;
            if (bus.rd) begin
                if (addr_is(bus.addr, etc_pkg::ADDR_COUNT)) begin
                    rdata_q <= count_q; // [R03]
                end else if (addr_is(bus.addr, etc_pkg::ADDR_CTRL)) begin
                    rdata_q <= ctrl_q & etc_pkg::CTRL_WMASK; // [R14]
                end else if (addr_is(bus.addr, etc_pkg::ADDR_IRQ)) begin
                    rdata_q[etc_pkg::IRQ_FLAG_BIT] <= flag_q; // [R06]
                    rdata_q[etc_pkg::IRQ_EN_BIT] <= irq_en_q; // [R07]
                end else if (addr_is(bus.addr, etc_pkg::ADDR_PORT)) begin
                    rdata_q[etc_pkg::PFD_BIT] <= latch_q; // [R16]
                end
            end
        end
    end
    assign bus_rdata = rdata_q;

    // checks
    overflow_reload_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && overflow && !wr_count |=> count_q == $past(preload_q)) // [R05]
        else $error("overflow did not reload preload");
    flag_set_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && overflow |=> flag_q) // [R06]
        else $error("overflow flag not set");
    irq_gate_a: assert property (@(posedge clk) disable iff (reset)
        !irq_en_q |-> !irq) // [R07]
        else $error("irq raised while disabled");
    read_block_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && rd_count && !wr_count |=> count_q == $past(count_q)) // [R03]
        else $error("counter moved during read");
    read_data_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && rd_count |=> bus_rdata == $past(count_q)) // [R03]
        else $error("wrong count read back");
    write_off_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_count && !run |=> count_q == $past(bus_wdata) && preload_q == count_q) // [R02]
        else $error("stopped write did not load");
    write_on_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_count && run && !overflow |=> count_q != $past(bus_wdata)
        || $past(count_q) == $past(bus_wdata) || $past(count_step)) // [R02]
        else $error("running write disturbed counter");
    run_hold_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && !pulse_mode && !wr_ctrl && run |=> run) // [R12]
        else $error("run cleared without write");
    pulse_end_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && pulse_done && !wr_ctrl |=> !run) // [R10]
        else $error("run not cleared after pulse");
    bit5_zero_a: assert property (@(posedge clk) disable iff (reset)
        (ctrl_q & ~etc_pkg::CTRL_WMASK) == etc_pkg::ZERO8) // [R14]
        else $error("control bit 5 set");
    pfd_toggle_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && overflow |=> pfd_q != $past(pfd_q)) // [R17]
        else $error("divider did not toggle");
    stopped_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && !run && !wr_count |=> count_q == $past(count_q)) // [R12]
        else $error("counter moved while off");

    // event, timer and unused mode counting
    event_count_a: assert property (@(posedge clk) disable iff (reset) // [R08]
        clk_en && mode == etc_pkg::ETC_MODE_EVENT && run && !rd_count && !wr_count && (polarity ? pin_fall : pin_rise) && count_q != etc_pkg::COUNT_MAX |=> count_q == $past(count_q) + 8'h01)
        else $error("event edge not counted");
    event_skip_a: assert property (@(posedge clk) disable iff (reset) // [R08]
        clk_en && mode == etc_pkg::ETC_MODE_EVENT && !(polarity ? pin_fall : pin_rise) && !wr_count |=> count_q == $past(count_q))
        else $error("counted without qualifying edge");
    mode_idle_a: assert property (@(posedge clk) disable iff (reset) // [R04]
        clk_en && mode == etc_pkg::ETC_MODE_NONE && !wr_count |=> count_q == $past(count_q))
        else $error("unused mode counted");
    timer_step_a: assert property (@(posedge clk) disable iff (reset) // [R01]
        clk_en && mode == etc_pkg::ETC_MODE_TIMER && run && psc_tick && !rd_count && !wr_count && count_q != etc_pkg::COUNT_MAX |=> count_q == $past(count_q) + 8'h01)
        else $error("timer tick not counted");
    timer_wait_a: assert property (@(posedge clk) disable iff (reset) // [R13]
        clk_en && mode == etc_pkg::ETC_MODE_TIMER && !psc_tick && !wr_count |=> count_q == $past(count_q))
        else $error("timer counted between ticks");
    psc_rate_a: assert property (@(posedge clk) disable iff (reset) // [R13]
        psc_tick |-> psc_q[etc_pkg::PSC_LSB] || psc_sel == 3'h0)
        else $error("prescale tick on even chain value");

    // pulse width measurement and overflow wake-up
    pulse_idle_a: assert property (@(posedge clk) disable iff (reset) // [R09]
        clk_en && pulse_mode && !measuring_q && !wr_count |=> count_q == $past(count_q))
        else $error("pulse counted before start edge");
    pulse_arm_a: assert property (@(posedge clk) disable iff (reset) // [R09]
        clk_en && pulse_mode && run && !measuring_q && start_edge |=> measuring_q)
        else $error("start edge did not arm");
    pulse_stop_a: assert property (@(posedge clk) disable iff (reset) // [R10]
        clk_en && pulse_done |=> !measuring_q)
        else $error("measurement went on after stop");
    wake_pulse_a: assert property (@(posedge clk) disable iff (reset) // [R15]
        clk_en && overflow |-> wake_up)
        else $error("overflow without wake pulse");

    // flags, port, pins, prescaler chain and register writes
    irq_follow_a: assert property (@(posedge clk) disable iff (reset) // [R07]
        irq_en_q && flag_q |-> irq)
        else $error("enabled flag did not raise irq");
    flag_hold_a: assert property (@(posedge clk) disable iff (reset) // [R06]
        clk_en && flag_q && !wr_irq |=> flag_q)
        else $error("flag dropped without write");
    flag_clear_a: assert property (@(posedge clk) disable iff (reset) // [R06]
        clk_en && wr_irq && !overflow && !bus_wdata[etc_pkg::IRQ_FLAG_BIT] |=> !flag_q)
        else $error("flag clear ignored");
    port_off_a: assert property (@(posedge clk) disable iff (reset) // [R16]
        !latch_q |-> !port_a_bit3)
        else $error("port active with latch low");
    port_pass_a: assert property (@(posedge clk) disable iff (reset) // [R16]
        freq_out_option && latch_q |-> port_a_bit3 == pfd_q)
        else $error("port does not carry divider");
    sync_path_a: assert property (@(posedge clk) disable iff (reset) // [R21]
        clk_en ##1 clk_en |=> pin_s2_q == $past(count_and_event_pin, 2))
        else $error("pin synchroniser delay wrong");
    pwm_step_a: assert property (@(posedge clk) disable iff (reset) // [R18]
        clk_en |=> pwm_time_base == 7'($past(psc_q) + etc_pkg::PSC_ONE))
        else $error("prescale chain did not advance");
    preload_write_a: assert property (@(posedge clk) disable iff (reset) // [R02]
        clk_en && wr_count |=> preload_q == $past(bus_wdata))
        else $error("preload not written");
    ctrl_write_a: assert property (@(posedge clk) disable iff (reset) // [R12]
        clk_en && wr_ctrl |=> ctrl_q == ($past(bus_wdata) & etc_pkg::CTRL_WMASK))
        else $error("control write lost");
endmodule // etc_timer
`default_nettype wire

// file: etc_pin_src.sv
// partner model: external event and pulse source on the timer pin
// assumes the bench calls drive() just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module etc_pin_src (
    // clock
    input wire logic clk,
    // pin
    output logic pin
);
    initial pin = 1'b0;

    // pin is asynchronous to the design, so any edge placement is legal
    task automatic drive(input logic v, input int n);
        pin <= v;
        repeat (n) @(posedge clk);
    endtask
endmodule // etc_pin_src
`default_nettype wire

// file: etc_timer_tb.sv
// bench for the event timer: a table of register cases, then timing cases
// assumes etc_timer, etc_pin_src, a 100 MHz clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module etc_timer_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic pin, port_a_bit3, irq, wake_up, pb;
    logic fo = 1'b1;
    logic [6:0] pwm_time_base;
    logic [6:0] pv;
    logic [7:0] rv;
    logic [7:0] rv2;
    int err_count = 0;
    int n_tests = 0;
    int per;
    // address, write data, expected read
    logic [23:0] rows [6] = '{24'h0EE7C7, 24'h0E2B0B, 24'h0D5A5A, 24'h0F0404,
        24'h100808, 24'h20FF00};

    always #5 clk = ~clk;

    etc_timer etc_timer_i (.clk(clk), .reset(reset), .clk_en(1'b1), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .count_and_event_pin(pin), .freq_out_option(fo), .port_a_bit3(port_a_bit3),
        .irq(irq), .wake_up(wake_up), .pwm_time_base(pwm_time_base));
    etc_pin_src etc_pin_src_i (.clk(clk), .pin(pin));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        d = bus_rdata;
    endtask

    // cycles until the next overflow pulse
    task automatic wake(output int n);
        n = 1;
        @(negedge clk);
        while (wake_up !== 1'b1 && n < 2000) begin
            n++;
            @(negedge clk);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #200_000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(etc_pkg::ADDR_CTRL, rv);
        chk("ctrl_reset", 16'(etc_pkg::CTRL_RESET), 16'(rv));
        wr(etc_pkg::ADDR_CTRL, 8'h90);
        wr(etc_pkg::ADDR_CTRL, 8'h80);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rv);
            chk("reg", 16'(rows[i][7:0]), 16'(rv));
        end
        $display("test registers done");
        wr(etc_pkg::ADDR_COUNT, 8'hFD);
        for (int s = 0; s < 8; s++) begin
            wr(etc_pkg::ADDR_CTRL, 8'h90 | 8'(s));
            wake(per);
            pb = port_a_bit3;
            wake(per);
            chk("period", 16'(3 << s), 16'(per));
            chk("pfd", 16'(!pb), 16'(port_a_bit3));
            chk("irq", 16'h0001, 16'(irq));
        end
        wr(etc_pkg::ADDR_CTRL, 8'h90);
        wr(etc_pkg::ADDR_COUNT, 8'h10);
        wake(per);
        wake(per);
        chk("reload", 16'h00F0, 16'(per));
        wr(etc_pkg::ADDR_IRQ, 8'h00);
        wake(per);
        @(negedge clk);
        chk("irq_off", 16'h0000, 16'(irq));
        wr(etc_pkg::ADDR_CTRL, 8'h80);
        rd(etc_pkg::ADDR_COUNT, rv);
        repeat (20) @(posedge clk);
        rd(etc_pkg::ADDR_COUNT, rv2);
        chk("stopped", 16'(rv), 16'(rv2));
        $display("test timer done");
        for (int p = 0; p < 2; p++) begin
            wr(etc_pkg::ADDR_CTRL, 8'h40);
            wr(etc_pkg::ADDR_COUNT, 8'h00);
            wr(etc_pkg::ADDR_CTRL, 8'h50 | 8'(p << 3));
            repeat (3) begin
                etc_pin_src_i.drive(1'b1, 4);
                etc_pin_src_i.drive(1'b0, 4);
            end
            etc_pin_src_i.drive(1'b1, 6);
            wr(etc_pkg::ADDR_CTRL, 8'h40);
            rd(etc_pkg::ADDR_COUNT, rv);
            chk("events", 16'(4 - p), 16'(rv));
            etc_pin_src_i.drive(1'b0, 6);
        end
        $display("test event done");
        wr(etc_pkg::ADDR_COUNT, 8'h00);
        wr(etc_pkg::ADDR_CTRL, 8'hD8);
        etc_pin_src_i.drive(1'b1, 20);
        etc_pin_src_i.drive(1'b0, 10);
        rd(etc_pkg::ADDR_CTRL, rv);
        chk("run_clear", 16'h00C8, 16'(rv));
        rd(etc_pkg::ADDR_COUNT, rv);
        chk("width", 16'h0001, 16'(rv >= 8'h13 && rv <= 8'h15));
        etc_pin_src_i.drive(1'b1, 30);
        etc_pin_src_i.drive(1'b0, 10);
        rd(etc_pkg::ADDR_COUNT, rv2);
        chk("held", 16'(rv), 16'(rv2));
        $display("test pulse done");
        @(negedge clk);
        pv = pwm_time_base;
        @(negedge clk);
        chk("pwm", 16'(7'(pv + 7'h01)), 16'(pwm_time_base));
        $display("test prescaler done");
        wr(etc_pkg::ADDR_PORT, 8'h00);
        @(negedge clk);
        chk("port_off", 16'h0000, 16'(port_a_bit3));
        wr(etc_pkg::ADDR_PORT, 8'h08);
        fo <= 1'b0;
        @(negedge clk);
        chk("port_plain", 16'h0001, 16'(port_a_bit3));
        $display("test port done");
        print_verdict();
    end
endmodule // etc_timer_tb
`default_nettype wire
